// [rtl/cpuam_defines.vh]
// Constants for the operand address generation unit.
// Included by the decoder and the address unit; definitions only.
`ifndef CPUAM_DEFINES_VH
`define CPUAM_DEFINES_VH
// Prefix byte values
`define CPUAM_PRE_Y 8'h90
`define CPUAM_PRE_IND 8'h92
`define CPUAM_PRE_YIND 8'h91
// Addressing mode codes (17 modes)
`define CPUAM_M_INH 5'h00
`define CPUAM_M_IMM 5'h01
`define CPUAM_M_DIR_S 5'h02
`define CPUAM_M_DIR_L 5'h03
`define CPUAM_M_IDX_0 5'h04
`define CPUAM_M_IDX_S 5'h05
`define CPUAM_M_IDX_L 5'h06
`define CPUAM_M_IND_S 5'h07
`define CPUAM_M_IND_L 5'h08
`define CPUAM_M_IIX_S 5'h09
`define CPUAM_M_IIX_L 5'h0a
`define CPUAM_M_REL_D 5'h0b
`define CPUAM_M_REL_I 5'h0c
`define CPUAM_M_BIT_D 5'h0d
`define CPUAM_M_BIT_I 5'h0e
`define CPUAM_M_BTR_D 5'h0f
`define CPUAM_M_BTR_I 5'h10
// Page zero limit and mask levels
`define CPUAM_PAGE0_MAX 16'h00ff
`define CPUAM_MASK_SET 2'h3
`define CPUAM_MASK_CLR 2'h0
// Inherent opcodes that touch the interrupt mask
`define CPUAM_OP_SETMASK 8'h9b
`define CPUAM_OP_CLRMASK 8'h9a
`endif

// [rtl/cpuam_mode_decode.v]
// Opcode and prefix to addressing mode decoder.
// Purely combinational; the prefix byte is held by the caller.
`timescale 1ns/1ps
`include "cpuam_defines.vh"
module cpuam_mode_decode (
   input wire [7:0] opcode,
   input wire [1:0] prefix_kind,
   output reg [4:0] mode,
   output reg use_y,
   output reg rmw_op,
   output reg illegal
);
   reg [4:0] base;
   // Base mode from the opcode column, then prefix rewrite
   always @* begin
      base = `CPUAM_M_INH;
      rmw_op = 1'b0;
      illegal = 1'b0;
      use_y = 1'b0;
      case (opcode[7:4])
         4'h0: base = `CPUAM_M_BTR_D;
         4'h1: base = `CPUAM_M_BIT_D;
         4'h2: base = `CPUAM_M_REL_D;
         4'h3: begin
            base = `CPUAM_M_DIR_S;
            rmw_op = 1'b1;
         end
         4'h6: begin
            base = `CPUAM_M_IDX_S;
            rmw_op = 1'b1;
         end
         4'h7: begin
            base = `CPUAM_M_IDX_0;
            rmw_op = 1'b1;
         end
         4'ha: base = `CPUAM_M_IMM;
         4'hb: base = `CPUAM_M_DIR_S;
         4'hc: base = `CPUAM_M_DIR_L;
         4'hd: base = `CPUAM_M_IDX_L;
         4'he: base = `CPUAM_M_IDX_S;
         4'hf: base = `CPUAM_M_IDX_0;
         default: base = `CPUAM_M_INH;
      endcase
      mode = base;
      case (prefix_kind)
         2'h1: use_y = 1'b1;
         2'h2, 2'h3: begin
            use_y = (prefix_kind == 2'h3);
            case (base)
               `CPUAM_M_DIR_S: mode = `CPUAM_M_IND_S;
               `CPUAM_M_DIR_L: mode = `CPUAM_M_IND_L;
               `CPUAM_M_IDX_S: mode = `CPUAM_M_IIX_S;
               `CPUAM_M_IDX_L: mode = `CPUAM_M_IIX_L;
               `CPUAM_M_REL_D: mode = `CPUAM_M_REL_I;
               `CPUAM_M_BIT_D: mode = `CPUAM_M_BIT_I;
               `CPUAM_M_BTR_D: mode = `CPUAM_M_BTR_I;
               default: illegal = 1'b1;
            endcase
            if (prefix_kind == 2'h3 && base != `CPUAM_M_IDX_S && base != `CPUAM_M_IDX_L)
               illegal = 1'b1;
         end
         default: use_y = 1'b0;
      endcase
      if (use_y && (mode == `CPUAM_M_REL_D || mode == `CPUAM_M_BIT_D || mode == `CPUAM_M_BTR_D))
         illegal = 1'b1;
      // Long forms never carry read-modify-write opcodes
      if (rmw_op && (mode == `CPUAM_M_IND_L || mode == `CPUAM_M_IIX_L))
         illegal = 1'b1;
   end
endmodule // cpuam_mode_decode

// [rtl/cpuam_addr_unit.v]
// Operand address generation and instruction length unit of the CPU core.
// Assumes a memory that answers a read request with mem_rdata one cycle later.
// x_reg and y_reg must hold while busy; the index is added late in the instruction.
//
// Summary of operation
// - Decode seventeen addressing modes across seven groups.
// - Short direct and short indirect forms reach page zero only, with fewer bytes.
// - Read-modify-write opcodes decode only with short forms and indexed without offset.
// - Inherent instruction is one byte, no operand fetch.
// - Immediate instruction is two bytes; second byte is the operand.
// - Short direct fetches one address byte, reach 00 to FF.
// - Long direct fetches a two-byte address, full 64 Kbyte reach.
// - Indexed address is unsigned sum of X or Y and offset.
// - Indexed without offset fetches nothing; address is the index.
// - Short indexed adds byte offset to index without wrap, to 1FE.
// - Long indexed adds index to two-byte offset, full reach.
// - Indirect modes read the operand address through a page zero pointer; relative indirect reads its branch offset there.
// - Short indirect reads a one-byte pointer, operand in page zero.
// - Long indirect reads a two-byte pointer, full reach.
// - Indirect indexed adds index to pointer read from memory.
// - Short indirect indexed adds index to byte pointer, to 1FE.
// - Set-mask opcode gives level 3, reset-mask opcode gives level 0.
// - Relative modes add a signed 8-bit offset to the PC.
// - Prefix 90 swaps X for Y.
// - Prefix 92 turns direct and offset X indexed forms indirect.
// - Prefix 91 turns X indirect indexed into Y indirect indexed.
`timescale 1ns/1ps
`include "cpuam_defines.vh"
module cpuam_addr_unit (
   input wire sys_clk,
   input wire arst_n,
   input wire start,
   input wire [15:0] pc_in,
   input wire [7:0] x_reg,
   input wire [7:0] y_reg,
   output reg mem_rd,
   output reg [15:0] mem_addr,
   input wire [7:0] mem_rdata,
   output reg done,
   output reg busy,
   output reg [4:0] mode,
   output reg [2:0] instr_len,
   output reg [15:0] eff_addr,
   output reg [7:0] imm_value,
   output reg [15:0] branch_target,
   output reg [1:0] int_mask,
   output reg illegal
);
   // Sequencer states
   localparam ST_IDLE = 3'h0;
   localparam ST_OP = 3'h1;
   localparam ST_OPER = 3'h2;
   localparam ST_PTR = 3'h3;
   localparam ST_REL = 3'h4;
   localparam ST_FIN = 3'h5;

   // Working registers of the sequencer
   reg [2:0] state;
   reg [15:0] pc;
   reg [1:0] prefix_kind;
   reg [7:0] opcode;
   reg [15:0] acc;
   reg [1:0] need;
   reg [1:0] got;
   reg [2:0] len;
   reg waiting;
   // Decoder results and the index register that they select
   wire [4:0] dec_mode;
   wire dec_use_y;
   wire dec_illegal;
   wire [7:0] idx = dec_use_y ? y_reg : x_reg;

   // Mode decoder sees the latched opcode and prefix
   cpuam_mode_decode u_dec (
      .opcode(opcode),
      .prefix_kind(prefix_kind),
      .mode(dec_mode),
      .use_y(dec_use_y),
      .rmw_op(), // Long-form misuse already shows in illegal
      .illegal(dec_illegal)
   );

   // Operand bytes after the opcode used to form the address
   function [1:0] oper_bytes;
      input [4:0] m;
      begin
         case (m)
            `CPUAM_M_INH, `CPUAM_M_IDX_0: oper_bytes = 2'd0;
            `CPUAM_M_DIR_L, `CPUAM_M_IDX_L: oper_bytes = 2'd2;
            default: oper_bytes = 2'd1;
         endcase
      end
   endfunction

   // Unsigned sum of index and base without wrapping at 8 bits; the 16-bit result wraps past FFFF
   function [15:0] idx_sum;
      input [15:0] b;
      input [7:0] i;
      begin
         idx_sum = b + {8'h00, i};
      end
   endfunction

   // Assemble a word from two bytes, high byte first
   function [15:0] word_of;
      input [15:0] a;
      input [7:0] b;
      begin
         word_of = {a[7:0], b};
      end
   endfunction

   // Sequencer: prefix, opcode, operand bytes, pointer, relative offset
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
         pc <= 16'h0000;
         prefix_kind <= 2'h0;
         opcode <= 8'h00;
         acc <= 16'h0000;
         need <= 2'h0;
         got <= 2'h0;
         len <= 3'h0;
         waiting <= 1'b0;
         mem_rd <= 1'b0;
         mem_addr <= 16'h0000;
         done <= 1'b0;
         busy <= 1'b0;
         mode <= 5'h00;
         instr_len <= 3'h0;
         eff_addr <= 16'h0000;
         imm_value <= 8'h00;
         branch_target <= 16'h0000;
         int_mask <= `CPUAM_MASK_SET;
         illegal <= 1'b0;
      end else begin
         // Strobes last one cycle unless a state raises them again
         done <= 1'b0;
         mem_rd <= 1'b0;
         case (state)
            // Wait for a start and fetch the first byte
            ST_IDLE: begin
               if (start) begin
                  // Prefix state is cleared for every new instruction
                  busy <= 1'b1;
                  pc <= pc_in;
                  prefix_kind <= 2'h0;
                  len <= 3'h0;
                  mem_rd <= 1'b1;
                  mem_addr <= pc_in;
                  waiting <= 1'b1;
                  state <= ST_OP;
               end
            end
            // Prefix or opcode byte; a second prefix is taken as the opcode
            ST_OP: begin
               if (waiting) begin
                  waiting <= 1'b0;
               end else begin
                  pc <= pc + 16'h0001;
                  len <= len + 3'h1;
                  if (mem_rdata == `CPUAM_PRE_Y && prefix_kind == 2'h0) begin
                     prefix_kind <= 2'h1;
                     mem_rd <= 1'b1;
                     mem_addr <= pc + 16'h0001;
                     waiting <= 1'b1;
                  end else if (mem_rdata == `CPUAM_PRE_IND && prefix_kind == 2'h0) begin
                     prefix_kind <= 2'h2;
                     mem_rd <= 1'b1;
                     mem_addr <= pc + 16'h0001;
                     waiting <= 1'b1;
                  end else if (mem_rdata == `CPUAM_PRE_YIND && prefix_kind == 2'h0) begin
                     prefix_kind <= 2'h3;
                     mem_rd <= 1'b1;
                     mem_addr <= pc + 16'h0001;
                     waiting <= 1'b1;
                  end else begin
                     opcode <= mem_rdata;
                     acc <= 16'h0000;
                     got <= 2'h0;
                     state <= ST_OPER;
                     waiting <= 1'b0;
                     need <= 2'h3; // Marks first pass to load decode
                  end
               end
            end
            // Decode, then collect the address or operand bytes
            ST_OPER: begin
               if (need == 2'h3) begin
                  mode <= dec_mode;
                  illegal <= dec_illegal;
                  need <= oper_bytes(dec_mode);
                  // Mask opcodes act only without a prefix
                  if (opcode == `CPUAM_OP_SETMASK && prefix_kind == 2'h0)
                     int_mask <= `CPUAM_MASK_SET;
                  else if (opcode == `CPUAM_OP_CLRMASK && prefix_kind == 2'h0)
                     int_mask <= `CPUAM_MASK_CLR;
                  // First operand byte is requested at once
                  if (oper_bytes(dec_mode) != 2'd0) begin
                     mem_rd <= 1'b1;
                     mem_addr <= pc;
                     waiting <= 1'b1;
                  end
               end else if (got == need) begin
                  // All address bytes in; form the address
                  case (mode)
                     `CPUAM_M_IMM: imm_value <= acc[7:0];
                     `CPUAM_M_IDX_0: eff_addr <= {8'h00, idx};
                     `CPUAM_M_IDX_S: eff_addr <= idx_sum({8'h00, acc[7:0]}, idx);
                     `CPUAM_M_IDX_L: eff_addr <= idx_sum(acc, idx);
                     `CPUAM_M_DIR_S, `CPUAM_M_BIT_D, `CPUAM_M_BTR_D:
                        eff_addr <= acc & `CPUAM_PAGE0_MAX;
                     `CPUAM_M_DIR_L: eff_addr <= acc;
                     default: eff_addr <= 16'h0000;
                  endcase
                  // Indirect forms go on to read the pointer
                  if (mode == `CPUAM_M_IND_S || mode == `CPUAM_M_IND_L || mode == `CPUAM_M_IIX_S ||
                      mode == `CPUAM_M_IIX_L || mode == `CPUAM_M_REL_I || mode == `CPUAM_M_BIT_I ||
                      mode == `CPUAM_M_BTR_I) begin
                     // Pointer lives in page zero at the byte just fetched
                     mem_rd <= 1'b1;
                     mem_addr <= {8'h00, acc[7:0]};
                     need <= (mode == `CPUAM_M_IND_L || mode == `CPUAM_M_IIX_L) ? 2'd2 : 2'd1;
                     got <= 2'h0;
                     waiting <= 1'b1;
                     state <= ST_PTR;
                  end else if (mode == `CPUAM_M_REL_D) begin
                     branch_target <= pc + {{8{acc[7]}}, acc[7:0]};
                     state <= ST_FIN;
                  end else if (mode == `CPUAM_M_BTR_D) begin
                     mem_rd <= 1'b1;
                     mem_addr <= pc;
                     waiting <= 1'b1;
                     state <= ST_REL;
                  end else begin
                     state <= ST_FIN;
                  end
               end else if (waiting) begin
                  waiting <= 1'b0;
               end else begin
                  // Newest byte enters below the earlier one
                  acc <= word_of(acc, mem_rdata);
                  got <= got + 2'h1;
                  pc <= pc + 16'h0001;
                  len <= len + 3'h1;
                  if (got + 2'h1 != need) begin
                     mem_rd <= 1'b1;
                     mem_addr <= pc + 16'h0001;
                     waiting <= 1'b1;
                  end
               end
            end
            // Pointer read from page zero, high byte first for words
            ST_PTR: begin
               if (waiting) begin
                  waiting <= 1'b0;
               end else if (got + 2'h1 != need) begin
                  acc <= word_of(acc, mem_rdata);
                  got <= got + 2'h1;
                  mem_rd <= 1'b1;
                  mem_addr <= mem_addr + 16'h0001;
                  waiting <= 1'b1;
               end else begin
                  case (mode)
                     `CPUAM_M_IND_S, `CPUAM_M_BIT_I: eff_addr <= {8'h00, mem_rdata};
                     `CPUAM_M_IND_L: eff_addr <= word_of(acc, mem_rdata);
                     `CPUAM_M_IIX_S: eff_addr <= idx_sum({8'h00, mem_rdata}, idx);
                     `CPUAM_M_IIX_L: eff_addr <= idx_sum(word_of(acc, mem_rdata), idx);
                     `CPUAM_M_REL_I: branch_target <= pc + {{8{mem_rdata[7]}}, mem_rdata};
                     default: eff_addr <= {8'h00, mem_rdata};
                  endcase
                  if (mode == `CPUAM_M_BTR_I) begin
                     eff_addr <= {8'h00, mem_rdata};
                     mem_rd <= 1'b1;
                     mem_addr <= pc;
                     waiting <= 1'b1;
                     state <= ST_REL;
                  end else begin
                     state <= ST_FIN;
                  end
               end
            end
            ST_REL: begin
               // Branch offset byte of a bit test and branch
               if (waiting) begin
                  waiting <= 1'b0;
               end else begin
                  pc <= pc + 16'h0001;
                  len <= len + 3'h1;
                  branch_target <= pc + 16'h0001 + {{8{mem_rdata[7]}}, mem_rdata};
                  state <= ST_FIN;
               end
            end
            // Publish the length and pulse done
            ST_FIN: begin
               instr_len <= len;
               done <= 1'b1;
               busy <= 1'b0;
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule // cpuam_addr_unit

// [verif/cpuam_monitor.sv]
// Checker for the operand address unit, bound to every instance of it.
// Assumes the unit's ports as declared and a single clock domain.
`timescale 1ns/1ps
`include "cpuam_defines.vh"
module cpuam_monitor (
   input wire sys_clk,
   input wire arst_n,
   input wire start,
   input wire busy,
   input wire mem_rd,
   input wire done,
   input wire [4:0] mode,
   input wire [2:0] instr_len,
   input wire [15:0] eff_addr,
   input wire [1:0] int_mask,
   input wire illegal
);
   reg [3:0] rd_cnt;
   wire fin;
   // Counts the reads issued since the start was taken
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) rd_cnt <= 4'h0;
      else if (start && !busy) rd_cnt <= 4'h0;
      else if (mem_rd) rd_cnt <= rd_cnt + 4'h1;
   end
   // A legal instruction has finished
   assign fin = done && !illegal;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   mode_range_a: assert property (done |-> mode <= `CPUAM_M_BTR_I)
      else $error("mode code out of range");
   start_done_a: assert property (start && !busy |-> ##[3:40] done)
      else $error("instruction did not finish in time");
   mask_level_a: assert property (int_mask == `CPUAM_MASK_SET || int_mask == `CPUAM_MASK_CLR)
      else $error("mask level other than 0 or 3");
   short_dir_a: assert property (fin && mode == `CPUAM_M_DIR_S |-> eff_addr[15:8] == 8'h00)
      else $error("short direct address beyond page zero");
   zero_idx_a: assert property (fin && mode == `CPUAM_M_IDX_0 |-> eff_addr[15:8] == 8'h00)
      else $error("unoffset index beyond page zero");
   short_idx_a: assert property (fin && mode == `CPUAM_M_IDX_S |-> eff_addr <= 16'h01fe)
      else $error("short indexed address beyond 1fe");
   short_ind_a: assert property (fin && mode == `CPUAM_M_IND_S |-> eff_addr[15:8] == 8'h00)
      else $error("short indirect address beyond page zero");
   short_iix_a: assert property (fin && mode == `CPUAM_M_IIX_S |-> eff_addr <= 16'h01fe)
      else $error("short indirect indexed address beyond 1fe");
   plain_len_a: assert property (fin && mode inside {`CPUAM_M_INH, `CPUAM_M_IMM, `CPUAM_M_DIR_S,
      `CPUAM_M_DIR_L, `CPUAM_M_IDX_0, `CPUAM_M_IDX_S, `CPUAM_M_IDX_L, `CPUAM_M_REL_D, `CPUAM_M_BIT_D,
      `CPUAM_M_BTR_D} |-> rd_cnt == {1'b0, instr_len}) else $error("reads differ from length");
   byte_ptr_a: assert property (fin && mode inside {`CPUAM_M_IND_S, `CPUAM_M_IIX_S, `CPUAM_M_BIT_I,
      `CPUAM_M_BTR_I} |-> rd_cnt == instr_len + 4'h1) else $error("byte pointer not read once");
   word_ptr_a: assert property (fin && mode inside {`CPUAM_M_IND_L, `CPUAM_M_IIX_L} |->
      rd_cnt == instr_len + 4'h2) else $error("word pointer not read twice");
endmodule // cpuam_monitor
bind cpuam_addr_unit cpuam_monitor mon (.sys_clk(sys_clk), .arst_n(arst_n), .start(start), .busy(busy),
   .mem_rd(mem_rd), .done(done), .mode(mode), .instr_len(instr_len), .eff_addr(eff_addr),
   .int_mask(int_mask), .illegal(illegal));

// [verif/cpuam_mem_model.sv]
// Program and data memory seen by the address unit.
// Assumes a read pulse answered one cycle later; the bench fills mem.
`timescale 1ns/1ps
module cpuam_mem_model (
   input wire sys_clk,
   input wire mem_rd,
   input wire [15:0] mem_addr,
   output reg [7:0] mem_rdata
);
   reg [7:0] mem [0:65535];
   initial mem_rdata = 8'h00;
   // Data valid one cycle after the request, then scrambled
   always @(posedge sys_clk) begin
      if (mem_rd) mem_rdata <= mem[mem_addr];
      else mem_rdata <= ~mem_rdata;
   end
endmodule // cpuam_mem_model

// [verif/test_cpu_addressing_mode_unit.sv]
// Self-checking bench for the operand address unit.
// Assumes the memory model beside it and the checker bound to the unit.
`timescale 1ns/1ps
`include "cpuam_defines.vh"
module test_cpu_addressing_mode_unit;
   reg sys_clk, arst_n, start;
   reg [15:0] pc_in;
   reg [7:0] x_reg, y_reg;
   wire mem_rd, done, busy, illegal;
   wire [15:0] mem_addr, eff_addr, branch_target;
   wire [7:0] mem_rdata, imm_value;
   wire [4:0] mode;
   wire [2:0] instr_len;
   wire [1:0] int_mask;
   integer n_fail, n_checks, cyc;
   cpuam_addr_unit uut (.sys_clk(sys_clk), .arst_n(arst_n), .start(start), .pc_in(pc_in), .x_reg(x_reg),
      .y_reg(y_reg), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .done(done), .busy(busy),
      .mode(mode), .instr_len(instr_len), .eff_addr(eff_addr), .imm_value(imm_value),
      .branch_target(branch_target), .int_mask(int_mask), .illegal(illegal));
   cpuam_mem_model mem_m (.sys_clk(sys_clk), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
   // Clock of 100 ns period
   initial sys_clk = 1'b0;
   always #50 sys_clk = ~sys_clk;
   // Cuts a hung run short
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         summarize;
      end
   end
   task summarize;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_fail);
         if (n_fail == 0 && n_checks > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   task chk(input string what, input [15:0] seen, input [15:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   // Loads four code bytes at pc, starts the unit and waits for done
   task exec(input [15:0] pc, input [31:0] code);
      integer k;
      begin
         mem_m.mem[pc] = code[31:24];
         mem_m.mem[pc + 16'h0001] = code[23:16];
         mem_m.mem[pc + 16'h0002] = code[15:8];
         mem_m.mem[pc + 16'h0003] = code[7:0];
         pc_in = pc;
         start = 1'b1;
         @(negedge sys_clk);
         start = 1'b0;
         chk("busy", {15'h0, busy}, 16'h1);
         k = 0;
         while (done !== 1'b1 && k < 60) begin
            @(negedge sys_clk);
            k = k + 1;
         end
         chk("done", {15'h0, done}, 16'h1);
         chk("idle", {15'h0, busy}, 16'h0);
      end
   endtask
   // Runs one instruction; an expected address of ffff is not compared
   task run(input [15:0] pc, input [31:0] code, input [4:0] em, input [2:0] el, input [15:0] ea);
      begin
         exec(pc, code);
         chk("mode", {11'h0, mode}, {11'h0, em});
         chk("length", {13'h0, instr_len}, {13'h0, el});
         if (ea !== 16'hffff) chk("address", eff_addr, ea);
         chk("illegal", {15'h0, illegal}, 16'h0);
      end
   endtask
   task t_reset;
      begin
         repeat (10) @(negedge sys_clk);
         chk("mask at reset", {14'h0, int_mask}, 16'h3);
         arst_n = 1'b1;
         @(negedge sys_clk);
      end
   endtask
   task t_inherent;
      begin
         run(16'h1000, 32'h9a000000, `CPUAM_M_INH, 3'h1, 16'hffff);
         chk("mask cleared", {14'h0, int_mask}, 16'h0);
         run(16'h1010, 32'h9b000000, `CPUAM_M_INH, 3'h1, 16'hffff);
         chk("mask set", {14'h0, int_mask}, 16'h3);
         run(16'h1020, 32'h909d0000, `CPUAM_M_INH, 3'h2, 16'hffff);
      end
   endtask
   task t_immediate;
      begin
         run(16'h1100, 32'ha6550000, `CPUAM_M_IMM, 3'h2, 16'hffff);
         chk("operand", {8'h0, imm_value}, 16'h0055);
         run(16'h1110, 32'h90a6aa00, `CPUAM_M_IMM, 3'h3, 16'hffff);
         chk("operand", {8'h0, imm_value}, 16'h00aa);
      end
   endtask
   task t_direct;
      begin
         run(16'h1200, 32'hb6800000, `CPUAM_M_DIR_S, 3'h2, 16'h0080);
         run(16'h1210, 32'hc6123400, `CPUAM_M_DIR_L, 3'h3, 16'h1234);
         run(16'h1220, 32'h36800000, `CPUAM_M_DIR_S, 3'h2, 16'h0080);
      end
   endtask
   task t_indexed;
      begin
         run(16'h1300, 32'hf6000000, `CPUAM_M_IDX_0, 3'h1, 16'h00ff);
         run(16'h1310, 32'he6ff0000, `CPUAM_M_IDX_S, 3'h2, 16'h01fe);
         run(16'h1320, 32'hd6123400, `CPUAM_M_IDX_L, 3'h3, 16'h1333);
         run(16'h1330, 32'h90e60500, `CPUAM_M_IDX_S, 3'h3, 16'h0015);
      end
   endtask
   task t_indirect;
      begin
         mem_m.mem[16'h0040] = 8'h20;
         mem_m.mem[16'h0041] = 8'h7f;
         run(16'h1400, 32'h92b64000, `CPUAM_M_IND_S, 3'h3, 16'h0020);
         run(16'h1410, 32'h92c64000, `CPUAM_M_IND_L, 3'h3, 16'h207f);
         run(16'h1420, 32'h92e64000, `CPUAM_M_IIX_S, 3'h3, 16'h011f);
         run(16'h1430, 32'h92d64000, `CPUAM_M_IIX_L, 3'h3, 16'h217e);
         run(16'h1440, 32'h91e64000, `CPUAM_M_IIX_S, 3'h3, 16'h0030);
      end
   endtask
   task t_illegal;
      begin
         exec(16'h1600, 32'h91b64000);
         chk("wrong prefix", {15'h0, illegal}, 16'h1);
         exec(16'h1610, 32'h90204000);
         chk("y on relative", {15'h0, illegal}, 16'h1);
         exec(16'h1620, 32'h92a65500);
         chk("indirect immediate", {15'h0, illegal}, 16'h1);
      end
   endtask
   task t_relative;
      begin
         run(16'h1500, 32'h20fe0000, `CPUAM_M_REL_D, 3'h2, 16'hffff);
         chk("target", branch_target, 16'h1500);
         run(16'h1510, 32'h207f0000, `CPUAM_M_REL_D, 3'h2, 16'hffff);
         chk("target", branch_target, 16'h1591);
         run(16'h1520, 32'h00400500, `CPUAM_M_BTR_D, 3'h3, 16'h0040);
         chk("target", branch_target, 16'h1528);
         run(16'h1530, 32'h10400000, `CPUAM_M_BIT_D, 3'h2, 16'h0040);
         run(16'h1540, 32'h92104000, `CPUAM_M_BIT_I, 3'h3, 16'h0020);
         run(16'h1550, 32'h92004005, `CPUAM_M_BTR_I, 3'h4, 16'h0020);
         chk("target", branch_target, 16'h1559);
         exec(16'h1560, 32'h92204000);
         chk("mode", {11'h0, mode}, {11'h0, `CPUAM_M_REL_I});
         chk("target", branch_target, 16'h1583);
      end
   endtask
   // Main sequence
   initial begin
      n_fail = 0;
      n_checks = 0;
      cyc = 0;
      arst_n = 1'b0;
      start = 1'b0;
      pc_in = 16'h0000;
      x_reg = 8'hff;
      y_reg = 8'h10;
      t_reset;
      t_inherent;
      t_immediate;
      t_direct;
      t_indexed;
      t_indirect;
      t_illegal;
      t_relative;
      summarize;
   end
endmodule // test_cpu_addressing_mode_unit
